// File: core/sar_pkg.sv
// shared constants and types for the successive-approximation control block
package sar_pkg;

  // ----------------------------------------------------------------
  // data path widths
  // ----------------------------------------------------------------
  localparam int unsigned RES_BITS   = 16;          // result width
  localparam int unsigned ADDR_BITS  = 8;           // register address width
  localparam int unsigned DATA_BITS  = 32;          // register data width
  localparam int unsigned IDX_BITS   = 4;           // bit index width
  localparam int unsigned SYNC_CNT   = 2;           // pin inputs that are synchronised

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CONFIG  = 8'h00;       // span control, overvoltage flag
  localparam logic [7:0] OFF_RESULT  = 8'h04;       // last conversion code
  localparam logic [7:0] OFF_IRQ_ST  = 8'h08;       // sticky event bits
  localparam logic [7:0] OFF_IRQ_MSK = 8'h0c;       // event mask
  localparam logic [7:0] OFF_STATUS  = 8'h10;       // live busy and clamp state

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CFG_SPAN_BIT  = 0;        // span compression enable
  localparam int unsigned CFG_OVN_BIT   = 1;        // overvoltage flag, active low
  localparam int unsigned EV_DONE_BIT   = 0;        // conversion finished
  localparam int unsigned EV_OV_BIT     = 1;        // clamp started to conduct
  localparam int unsigned EV_BITS       = 2;        // number of events
  localparam int unsigned ST_BUSY_BIT   = 0;        // conversion running
  localparam int unsigned ST_CLAMP_BIT  = 1;        // clamp conducting now
  localparam int unsigned PIN_CNV       = 0;        // sync slot of conversion start
  localparam int unsigned PIN_CLAMP     = 1;        // sync slot of clamp sense

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [15:0] CODE_ZERO    = 16'h0000;  // midscale code
  localparam logic [15:0] MSB_FLIP     = 16'h8000;  // offset binary to two's complement
  localparam logic [15:0] TRIAL_MSB    = 16'h8000;  // first trial weight, half scale
  localparam logic [3:0]  IDX_MSB      = 4'hf;      // first bit decided
  localparam logic [3:0]  IDX_LSB      = 4'h0;      // last bit decided
  localparam logic [1:0]  EV_NONE      = 2'h0;      // no event pending
  localparam logic [31:0] RD_ZERO      = 32'h0000_0000; // unmapped read answer

  // ----------------------------------------------------------------
  // internal conversion clock
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 20_000_000;  // system clock rate
  localparam int unsigned CONV_CLK_HZ   = 10_000_000;  // bit decision rate
  localparam int unsigned CONV_DIV      = CLK_HZ / CONV_CLK_HZ; // cycles per decision
  localparam logic [3:0]  DIV_LAST      = 4'(CONV_DIV - 1);    // divider terminal count
  localparam logic [3:0]  DIV_ZERO      = 4'h0;                // divider restart value

  // ----------------------------------------------------------------
  // conversion sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEQ_ACQUIRE,                                    // arrays track the inputs
    SEQ_OPEN_SW,                                    // comparator ground switches open
    SEQ_GROUND,                                     // arrays moved to ground
    SEQ_CONVERT,                                    // bit decisions running
    SEQ_FINISH                                      // code latched, busy released
  } seq_state_t;

endpackage

// File: core/sar_if.sv
// carrier between the sequencer and the bit decision engine
`timescale 1ns/1ps
`default_nettype none

interface sar_if;
  logic        start;   // one-cycle pulse, begin bit decisions
  logic        tick;    // one-cycle pulse, one decision step
  logic        comp;    // comparator: input at or above trial level
  logic        done;    // one-cycle pulse, last bit decided
  logic [15:0] trial;   // switch pattern driven into the arrays
  logic [15:0] code;    // decided bits, offset binary

  modport engine (input start, input tick, input comp, output done, output trial, output code);
  modport ctrl   (output start, output tick, output comp, input done, input trial, input code);
endinterface

`default_nettype wire

// File: core/sar_bit_engine.sv
// binary-weighted bit decision engine, most significant bit first
`timescale 1ns/1ps
`default_nettype none

module sar_bit_engine (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // sequencer side
  sar_if.engine     bus
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [3:0]  idx_reg;     // bit under trial
  logic [15:0] code_reg;    // bits kept so far
  logic [15:0] trial_reg;   // pattern on the arrays
  logic        run_reg;     // decisions in progress
  logic        done_reg;    // end pulse

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  localparam logic [15:0] TRIAL_ONE = 16'h0001;         // weight of one step in 65,536

  wire [15:0] weight     = 16'(TRIAL_ONE << idx_reg);   // weight of current bit
  wire [15:0] kept       = bus.comp ? (code_reg | weight) : code_reg; // keep or drop
  wire        last       = (idx_reg == sar_pkg::IDX_LSB);
  wire [3:0]  idx_next   = 4'(idx_reg - 4'h1);
  wire [15:0] next_w     = 16'(TRIAL_ONE << idx_next);  // weight halves each step
  wire        step       = run_reg & bus.tick;

  assign bus.done  = done_reg;
  assign bus.trial = trial_reg;
  assign bus.code  = code_reg;

  // ----------------------------------------------------------------
  // decision steps
  // ----------------------------------------------------------------
  // start loads half scale; each tick keeps or drops one bit
  always_ff @(posedge clk) begin
    if (!rstn) begin
      idx_reg   <= sar_pkg::IDX_MSB;
      code_reg  <= sar_pkg::CODE_ZERO;
      trial_reg <= sar_pkg::CODE_ZERO;
      run_reg   <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (bus.start) begin
        // begin at the most significant bit
        idx_reg   <= sar_pkg::IDX_MSB;
        code_reg  <= sar_pkg::CODE_ZERO;
        trial_reg <= sar_pkg::TRIAL_MSB;
        run_reg   <= 1'b1;
      end else if (step) begin
        code_reg <= kept;
        if (last) begin
          // all ones saturates high, all zeros low
          run_reg   <= 1'b0;
          done_reg  <= 1'b1;
          trial_reg <= sar_pkg::CODE_ZERO;
        end else begin
          idx_reg   <= idx_next;
          trial_reg <= kept | next_w;
        end
      end
    end
  end

endmodule

`default_nettype wire

// File: core/sar_conversion_output_coding.sv
// conversion sequencer, output coding, overvoltage flag and register port
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module sar_conversion_output_coding (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // pins from the outside
  input  wire logic        conversion_start_input,
  input  wire logic        clamp_conducting,
  // analog front end
  input  wire logic        comparator_out,
  output logic             comparator_ground_switch_pos,
  output logic             comparator_ground_switch_neg,
  output logic             array_to_inputs,
  output logic             array_to_ground,
  output logic [15:0]      array_trial,
  output logic             span_compress_en,
  // conversion results
  output logic             busy,
  output logic [15:0]      result_code,
  output logic [1:0]       result_status,
  output logic             overvoltage_flag_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pin_raw;            // pins entering the synchronisers
  logic [1:0] sync1_reg;          // first stage, read only by the second
  logic [1:0] sync2_reg;          // second stage
  logic [1:0] sync3_reg;          // third stage
  logic [1:0] pin_reg;            // accepted level

  assign pin_raw[sar_pkg::PIN_CNV]   = conversion_start_input;
  assign pin_raw[sar_pkg::PIN_CLAMP] = clamp_conducting;

  genvar gi;
  generate
    for (gi = 0; gi < sar_pkg::SYNC_CNT; gi++) begin : g_sync
      // a change counts once second and third stage agree
      always_ff @(posedge clk) begin
        if (!rstn) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          sync3_reg[gi] <= 1'b0;
          pin_reg[gi]   <= 1'b0;
        end else begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
          if (sync2_reg[gi] == sync3_reg[gi]) begin
            pin_reg[gi] <= sync3_reg[gi];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // start edge and clamp sense
  // ----------------------------------------------------------------
  logic cnv_prev_reg;             // last accepted start level
  logic clamp_prev_reg;           // last accepted clamp level

  wire cnv_level   = pin_reg[sar_pkg::PIN_CNV];
  wire clamp_level = pin_reg[sar_pkg::PIN_CLAMP];
  wire cnv_rise    = cnv_level & ~cnv_prev_reg;
  wire clamp_rise  = clamp_level & ~clamp_prev_reg;

  // remember levels for edge detection
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnv_prev_reg   <= 1'b0;
      clamp_prev_reg <= 1'b0;
    end else begin
      cnv_prev_reg   <= cnv_level;
      clamp_prev_reg <= clamp_level;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  sar_pkg::seq_state_t state_reg;   // current phase
  sar_pkg::seq_state_t state_next;  // next phase
  sar_if               eng ();      // link to the bit engine

  // phase changes; a start edge outside acquisition is ignored
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      sar_pkg::SEQ_ACQUIRE: begin
        if (cnv_rise) begin
          state_next = sar_pkg::SEQ_OPEN_SW;
        end
      end
      sar_pkg::SEQ_OPEN_SW: begin
        state_next = sar_pkg::SEQ_GROUND;
      end
      sar_pkg::SEQ_GROUND: begin
        state_next = sar_pkg::SEQ_CONVERT;
      end
      sar_pkg::SEQ_CONVERT: begin
        if (eng.done) begin
          state_next = sar_pkg::SEQ_FINISH;
        end
      end
      sar_pkg::SEQ_FINISH: begin
        state_next = sar_pkg::SEQ_ACQUIRE;
      end
    endcase
  end

  // phase register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= sar_pkg::SEQ_ACQUIRE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // front end switch controls
  // ----------------------------------------------------------------
  wire sw_closed_next = (state_next == sar_pkg::SEQ_ACQUIRE);
  wire to_in_next     = (state_next == sar_pkg::SEQ_ACQUIRE) ||
                        (state_next == sar_pkg::SEQ_OPEN_SW);

  // switches open one cycle before the arrays leave the inputs
  always_ff @(posedge clk) begin
    if (!rstn) begin
      comparator_ground_switch_pos <= 1'b1;
      comparator_ground_switch_neg <= 1'b1;
      array_to_inputs              <= 1'b1;
      array_to_ground              <= 1'b0;
    end else begin
      comparator_ground_switch_pos <= sw_closed_next;
      comparator_ground_switch_neg <= sw_closed_next;
      array_to_inputs              <= to_in_next;
      array_to_ground              <= ~to_in_next;
    end
  end

  // ----------------------------------------------------------------
  // internal conversion clock
  // ----------------------------------------------------------------
  logic [3:0] div_reg;            // decision rate divider
  wire        div_end = (div_reg == sar_pkg::DIV_LAST);

  // free count only while converting, no serial clock needed
  always_ff @(posedge clk) begin
    if (!rstn) begin
      div_reg <= sar_pkg::DIV_ZERO;
    end else if (state_reg != sar_pkg::SEQ_CONVERT || div_end) begin
      div_reg <= sar_pkg::DIV_ZERO;
    end else begin
      div_reg <= 4'(div_reg + 4'h1);
    end
  end

  assign eng.start = (state_reg == sar_pkg::SEQ_GROUND);
  assign eng.tick  = (state_reg == sar_pkg::SEQ_CONVERT) & div_end;
  assign eng.comp  = comparator_out;

  sar_bit_engine u_engine (
    .clk  (clk),
    .rstn (rstn),
    .bus  (eng)
  );

  // ----------------------------------------------------------------
  // registers and flags
  // ----------------------------------------------------------------
  logic       span_reg;           // span compression enable
  logic       ov_n_reg;           // sticky overvoltage flag, low when set
  logic [1:0] ev_reg;             // sticky events
  logic [1:0] mask_reg;           // event enables

  // decode
  wire sel_cfg  = (reg_addr == sar_pkg::OFF_CONFIG);
  wire sel_res  = (reg_addr == sar_pkg::OFF_RESULT);
  wire sel_ist  = (reg_addr == sar_pkg::OFF_IRQ_ST);
  wire sel_msk  = (reg_addr == sar_pkg::OFF_IRQ_MSK);
  wire sel_sta  = (reg_addr == sar_pkg::OFF_STATUS);
  wire cfg_read = reg_rd & sel_cfg;

  // offset binary with msb flipped is two's complement
  wire [15:0] coded = eng.code ^ sar_pkg::MSB_FLIP;

  // event sources
  wire [1:0] ev_set = {clamp_rise, eng.done};
  wire [1:0] ev_clr = (reg_wr & sel_ist) ? reg_wdata[1:0] : sar_pkg::EV_NONE;

  // read data selection
  wire [31:0] cfg_word = {30'h0, ov_n_reg, span_reg};
  wire [31:0] res_word = {14'h0, ov_n_reg, busy, result_code};
  wire [31:0] ist_word = {30'h0, ev_reg};
  wire [31:0] msk_word = {30'h0, mask_reg};
  wire [31:0] sta_word = {30'h0, clamp_level, busy};
  wire [31:0] rd_word  = sel_cfg ? cfg_word :
                         sel_res ? res_word :
                         sel_ist ? ist_word :
                         sel_msk ? msk_word :
                         sel_sta ? sta_word : sar_pkg::RD_ZERO;

  // config, mask and interrupt status writes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      span_reg <= 1'b0;
      mask_reg <= sar_pkg::EV_NONE;
      ev_reg   <= sar_pkg::EV_NONE;
    end else begin
      if (reg_wr & sel_cfg) begin
        span_reg <= reg_wdata[sar_pkg::CFG_SPAN_BIT];
      end
      if (reg_wr & sel_msk) begin
        mask_reg <= reg_wdata[1:0];
      end
      // a new event beats a clear in the same cycle
      ev_reg <= (ev_reg & ~ev_clr) | ev_set;
    end
  end

  // sticky overvoltage flag, active low, not writable
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ov_n_reg <= 1'b1;
    end else if (clamp_level) begin
      ov_n_reg <= 1'b0;
    end else if (cfg_read) begin
      ov_n_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // result, busy and outputs
  // ----------------------------------------------------------------
  // busy rises with the start edge and falls with the valid code
  always_ff @(posedge clk) begin
    if (!rstn) begin
      busy          <= 1'b0;
      result_code   <= sar_pkg::CODE_ZERO;
      result_status <= 2'h3;
    end else begin
      if (state_reg == sar_pkg::SEQ_ACQUIRE && cnv_rise) begin
        busy <= 1'b1;
      end else if (eng.done) begin
        busy          <= 1'b0;
        result_code   <= coded;
        result_status <= {ov_n_reg & ~clamp_level, span_reg};
      end
    end
  end

  // read data, interrupt and front end scaling
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_rdata          <= sar_pkg::RD_ZERO;
      irq                <= 1'b0;
      span_compress_en   <= 1'b0;
      overvoltage_flag_n <= 1'b1;
      array_trial        <= sar_pkg::CODE_ZERO;
    end else begin
      reg_rdata          <= reg_rd ? rd_word : sar_pkg::RD_ZERO;
      irq                <= |((ev_reg | ev_set) & mask_reg);
      span_compress_en   <= span_reg;
      overvoltage_flag_n <= ov_n_reg;
      array_trial        <= eng.trial;
    end
  end

endmodule

`default_nettype wire

// File: tb/analog_front_model.sv
// comparator model of the analog front end holding one differential input level
`timescale 1ns/1ps
`default_nettype none

module analog_front_model (
  // trial pattern from the arrays
  input  wire logic        [15:0] array_trial,
  // held input as signed offset binary; outside 0..ffff means out of range
  input  wire logic signed [17:0] level,
  // decision back to the logic
  output logic                    comparator_out
);
  // keep the bit while the held input is at or above the trial level
  assign comparator_out = ($signed({2'b00, array_trial}) <= level);
endmodule

`default_nettype wire

// File: tb/sar_conversion_output_coding_checker.sv
// port level assertions for the conversion control block
`timescale 1ns/1ps
`default_nettype none

module sar_conversion_output_coding_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // pins and front end
  input wire logic        conversion_start_input,
  input wire logic        clamp_conducting,
  input wire logic        comparator_ground_switch_pos,
  input wire logic        comparator_ground_switch_neg,
  input wire logic        array_to_inputs,
  input wire logic        array_to_ground,
  input wire logic [15:0] array_trial,
  // results and register port
  input wire logic        busy,
  input wire logic [15:0] result_code,
  input wire logic        overvoltage_flag_n,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd
);
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!rstn);

  // first cycle of a conversion
  sequence conv_begin_s;
    $rose(busy);
  endsequence

  // busy stays up for the whole decision run
  sequence conv_run_s;
    busy throughout (1'b1 ##34 1'b1);
  endsequence

  AST_START_EDGE: assert property (!busy && $rose(conversion_start_input) |->
    ##[1:10] $rose(busy)) else $error("start edge did not begin a conversion");
  AST_OPEN_FIRST: assert property (conv_begin_s |->
    !comparator_ground_switch_pos && !comparator_ground_switch_neg && array_to_inputs)
    else $error("switches not opened before arrays moved");
  AST_GROUND_NEXT: assert property (conv_begin_s |=>
    !array_to_inputs && array_to_ground) else $error("arrays not grounded after open");
  // the finish phase keeps the front end in conversion one cycle past busy
  AST_SW_BUSY: assert property (
    comparator_ground_switch_pos == !(busy || $past(busy)) &&
    comparator_ground_switch_neg == comparator_ground_switch_pos)
    else $error("ground switches disagree with busy");
  AST_IDLE_ARRAYS: assert property (!busy && !$past(busy) |->
    array_to_inputs && !array_to_ground) else $error("arrays not tracking inputs while idle");
  AST_MSB_FIRST: assert property (conv_begin_s |-> ##3 (array_trial == sar_pkg::TRIAL_MSB)
    ##2 (array_trial[14:0] == 15'h4000)) else $error("trial weights not msb first");
  AST_STEP_RATE: assert property (busy && $changed(array_trial) |=> $stable(array_trial))
    else $error("trial changed faster than the conversion clock");
  AST_BUSY_SPAN: assert property (conv_begin_s |-> conv_run_s ##1 !busy)
    else $error("busy length wrong");
  AST_RESULT_HOLD: assert property (!$fell(busy) |-> $stable(result_code))
    else $error("result changed outside conversion end");
  AST_OV_SET: assert property (clamp_conducting [*8] |=> !overvoltage_flag_n)
    else $error("flag not set while clamp conducts");
  AST_OV_CLEAR: assert property ($rose(overvoltage_flag_n) |->
    $past(reg_rd && reg_addr == sar_pkg::OFF_CONFIG) ||
    $past(reg_rd && reg_addr == sar_pkg::OFF_CONFIG, 2)) else $error("flag cleared without read");
endmodule

bind sar_conversion_output_coding sar_conversion_output_coding_checker checker_inst (
  .clk(clk), .rstn(rstn), .conversion_start_input(conversion_start_input),
  .clamp_conducting(clamp_conducting), .comparator_ground_switch_pos(comparator_ground_switch_pos),
  .comparator_ground_switch_neg(comparator_ground_switch_neg), .array_to_inputs(array_to_inputs),
  .array_to_ground(array_to_ground), .array_trial(array_trial), .busy(busy),
  .result_code(result_code), .overvoltage_flag_n(overvoltage_flag_n), .reg_addr(reg_addr),
  .reg_rd(reg_rd)
);

`default_nettype wire

// File: tb/tb_sar_conversion_output_coding.sv
// self-checking bench for the conversion control block
`timescale 1ns/1ps
`default_nettype none

module tb_sar_conversion_output_coding;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic               clk, rstn, conversion_start_input, clamp_conducting, comparator_out;
  logic               comparator_ground_switch_pos, comparator_ground_switch_neg;
  logic               array_to_inputs, array_to_ground, span_compress_en, busy, irq;
  logic               overvoltage_flag_n, reg_wr, reg_rd, exp_ovn, exp_span;
  logic [15:0]        array_trial, result_code;
  logic [1:0]         result_status;
  logic [7:0]         reg_addr;
  logic [31:0]        reg_wdata, reg_rdata, d;
  logic signed [17:0] level;                  // held analog input
  int                 error_cnt, compares, cycles;
  // input levels and codes: zero, +1, -1, top, bottom+1, bottom, over and under
  logic signed [17:0] lv_tab [8] = '{18'sh08000, 18'sh08001, 18'sh07fff, 18'sh0ffff,
                                     18'sh00001, 18'sh00000, 18'sh1ffff, 18'sh3ffff};
  logic [15:0]        exp_tab [8] = '{16'h0000, 16'h0001, 16'hffff, 16'h7fff,
                                      16'h8001, 16'h8000, 16'h7fff, 16'h8000};

  sar_conversion_output_coding sar_conversion_output_coding_inst (
    .clk(clk), .rstn(rstn), .conversion_start_input(conversion_start_input),
    .clamp_conducting(clamp_conducting), .comparator_out(comparator_out),
    .comparator_ground_switch_pos(comparator_ground_switch_pos),
    .comparator_ground_switch_neg(comparator_ground_switch_neg),
    .array_to_inputs(array_to_inputs), .array_to_ground(array_to_ground),
    .array_trial(array_trial), .span_compress_en(span_compress_en), .busy(busy),
    .result_code(result_code), .result_status(result_status),
    .overvoltage_flag_n(overvoltage_flag_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq)
  );

  analog_front_model analog_front_model_inst (
    .array_trial(array_trial), .level(level), .comparator_out(comparator_out)
  );

  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (busy !== v && n < 60);
    check("busy", {31'h0, busy}, {31'h0, v});
  endtask

  // one conversion; poke toggles the start pin while busy
  task automatic convert(input logic signed [17:0] lv, input logic [15:0] exp, input bit poke);
    @(posedge clk);
    level                  <= lv;
    conversion_start_input <= 1'b0;
    repeat (6) @(posedge clk);
    conversion_start_input <= 1'b1;
    wait_busy(1'b1);
    if (poke) begin
      @(posedge clk);
      conversion_start_input <= 1'b0;
      repeat (6) @(posedge clk);
      conversion_start_input <= 1'b1;
    end
    wait_busy(1'b0);
    check("result code", {16'h0, result_code}, {16'h0, exp});
    check("result status", {30'h0, result_status}, {30'h0, exp_ovn, exp_span});
    reg_read(sar_pkg::OFF_RESULT, d);
    check("result word", d, {14'h0, exp_ovn, 1'b0, exp});
    repeat (8) @(posedge clk);
    #1;
    check("no restart", {31'h0, busy}, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    conversion_start_input = 1'b0;
    clamp_conducting = 1'b0;
    level = 18'sh08000;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    exp_ovn = 1'b1;
    exp_span = 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    check("reset state", {25'h0, busy, overvoltage_flag_n, irq, comparator_ground_switch_pos,
          comparator_ground_switch_neg, array_to_inputs, array_to_ground}, 32'h2e);
    for (int i = 0; i < 8; i++) begin
      if (i == 6) begin
        reg_write(sar_pkg::OFF_CONFIG, 32'h1);
        reg_read(sar_pkg::OFF_CONFIG, d);
        check("config span", d, 32'h3);
        check("span pin", {31'h0, span_compress_en}, 32'h1);
        exp_span = 1'b1;
      end
      convert(lv_tab[i], exp_tab[i], i == 3);
    end
    // interrupt raise, mask, clear
    check("irq masked", {31'h0, irq}, 32'h0);
    reg_read(sar_pkg::OFF_IRQ_ST, d);
    check("done event", d, 32'h1);
    reg_write(sar_pkg::OFF_IRQ_MSK, 32'h3);
    reg_read(sar_pkg::OFF_IRQ_MSK, d);
    check("mask", d, 32'h3);
    check("irq raised", {31'h0, irq}, 32'h1);
    reg_write(sar_pkg::OFF_IRQ_ST, 32'h1);
    reg_read(8'h20, d);
    check("unmapped read", d, 32'h0);
    check("irq cleared", {31'h0, irq}, 32'h0);
    reg_write(sar_pkg::OFF_RESULT, 32'hffff_ffff);
    reg_read(sar_pkg::OFF_RESULT, d);
    check("result read only", d, 32'h0002_8000);
    // clamp conducts: flag set, sticky, cleared by a later read
    @(posedge clk);
    clamp_conducting <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    check("flag set", {31'h0, overvoltage_flag_n}, 32'h0);
    check("clamp irq", {31'h0, irq}, 32'h1);
    reg_read(sar_pkg::OFF_CONFIG, d);
    check("config clamped", d, 32'h1);
    reg_read(sar_pkg::OFF_STATUS, d);
    check("live clamp", d, 32'h2);
    check("flag held", {31'h0, overvoltage_flag_n}, 32'h0);
    exp_ovn = 1'b0;
    convert(18'sh08000, 16'h0000, 1'b0);
    reg_write(sar_pkg::OFF_IRQ_ST, 32'h3);
    @(posedge clk);
    clamp_conducting <= 1'b0;
    repeat (8) @(posedge clk);
    reg_write(sar_pkg::OFF_CONFIG, 32'h3);
    #1;
    check("flag not writable", {31'h0, overvoltage_flag_n}, 32'h0);
    check("irq idle", {31'h0, irq}, 32'h0);
    reg_read(sar_pkg::OFF_CONFIG, d);
    check("clearing read", d, 32'h1);
    @(posedge clk);
    #1;
    check("flag cleared", {31'h0, overvoltage_flag_n}, 32'h1);
    reg_read(sar_pkg::OFF_CONFIG, d);
    check("config after clear", d, 32'h3);
    report_and_stop();
  end
endmodule

`default_nettype wire
